/* design/scg_defs.vh */
// scg_defs.vh: offsets, field positions, reset values and codes of the
// sleep-mode clock gating block.
// assumes: included by bare name from the register design file and the dv files; the gate cell does not include it.
`ifndef SCG_DEFS_VH
`define SCG_DEFS_VH

// ----------------------------------------------------------------------
// register byte offsets from the system control base
// ----------------------------------------------------------------------
`define SCG_OFF_RUN_GATE 12'h104
`define SCG_OFF_SLEEP_GATE 12'h114
`define SCG_OFF_DEEP_GATE 12'h124
`define SCG_OFF_RUN_CFG 12'h160
`define SCG_OFF_IRQ_STATUS 12'h170
`define SCG_OFF_IRQ_MASK 12'h174
`define SCG_OFF_EFF_GATE 12'h178

// ----------------------------------------------------------------------
// gating register layout
// ----------------------------------------------------------------------
`define SCG_GATE_RESET 32'h00000000
`define SCG_GATE_IMPL 32'h010f1037
`define SCG_BIT_COMPARATOR_ZERO_GATE 5'h18
`define SCG_BIT_GPT3 5'h13
`define SCG_BIT_GPT2 5'h12
`define SCG_BIT_GPT1 5'h11
`define SCG_BIT_GPT0 5'h10
`define SCG_BIT_I2C_PORT_ZERO_GATE 5'h0c
`define SCG_BIT_SYNC_SERIAL_ONE_GATE 5'h05
`define SCG_BIT_SYNC_SERIAL_ZERO_GATE 5'h04
`define SCG_BIT_UART_PORT_TWO_GATE 5'h02
`define SCG_BIT_UART_PORT_ONE_GATE 5'h01
`define SCG_BIT_UART_PORT_ZERO_GATE 5'h00
`define SCG_NUM_UNITS 11

// ----------------------------------------------------------------------
// configuration and interrupt fields
// ----------------------------------------------------------------------
`define SCG_CFG_AUTO_BIT 0
`define SCG_CFG_RESET 32'h00000000
`define SCG_IRQ_FAULT_BIT 0
`define SCG_IRQ_UNMAP_BIT 1
`define SCG_IRQ_IMPL 32'h00000003
`define SCG_IRQ_RESET 32'h00000000

// ----------------------------------------------------------------------
// avalon-mm response codes
// ----------------------------------------------------------------------
`define SCG_RESP_OKAY 2'h0
`define SCG_RESP_SLVERR 2'h2

`endif

/* design/scg_gate_cell.v */
// scg_gate_cell.v: one unit's effective clock enable, chosen by power
// state and held in a flop so the downstream clock gate sees clean levels.
// assumes: clk is the system clock that the gated unit's clock gate uses.
`timescale 1ns/1ps
`default_nettype none

module scg_gate_cell (
	// clock and reset
	input wire clk,
	input wire reset,
	input wire ce,
	// candidate enables
	input wire run_en,
	input wire sleep_en,
	input wire deep_en,
	// power state selection
	input wire use_sleep,
	input wire use_deep,
	// enable towards the clock gate
	output wire gate_en
);

	reg gate_en_r;
	reg gate_en_nxt;

	// ------------------------------------------------------------------
	// selection
	// ------------------------------------------------------------------
	always @* begin
		gate_en_nxt = run_en; // (R14)
		if (use_deep) begin
			gate_en_nxt = deep_en; // (R05)
		end else if (use_sleep) begin
			gate_en_nxt = sleep_en; // (R05)
		end
	end

	// changes only at a clock edge: the latch in the gate never sees a
	// combinational glitch from the select mux
	always @(posedge clk) begin
		if (reset) begin
			gate_en_r <= 1'b0; // (R04)
		end else if (ce) begin
			gate_en_r <= gate_en_nxt; // (R14)
		end
	end

	assign gate_en = gate_en_r; // (R02)

endmodule // scg_gate_cell

`default_nettype wire

/* design/scg_sleep_gate.v */
// scg_sleep_gate.v: sleep-mode clock gating register with its run and
// deep-sleep companions, power-state selection of each unit's clock
// enable, bus fault flagging for gated units, and an interrupt block.
// assumes: one system clock; registers reached over avalon-mm with
// byte addresses; the interconnect reports each peripheral access as a
// one-cycle strobe on unit_access.
//
// Chosen here: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "scg_defs.vh"

// How it works
// (R01) sleep gating register is 32 bits at 0x114, resets to zero.
// (R02) each implemented bit set means its unit is clocked, clear means off.
// (R03) any access to a unit whose clock is off ends in a bus fault.
// (R04) all gating bits are zero after reset, so every unit starts off.
// (R05) sleep register rules in sleep, run register running, deep in deep sleep.
// (R06) sleep values apply only while the automatic gating select is set.
// (R07) bit 24 enables analog comparator 0.
// (R08) bits 19 to 16 enable general timers 3, 2, 1 and 0.
// (R09) bit 12 enables i2c module 0.
// (R10) bit 5 enables serial module 1, bit 4 serial module 0.
// (R11) bits 2, 1 and 0 enable uart modules 2, 1 and 0.
// (R12) reserved bits are read-only and read zero; software preserves them.
// (R13) run gating register with the same layout sits at 0x104.
// (R14) effective enable follows power state and changes glitch-free.
module scg_sleep_gate (
	// clock and reset
	input wire clk,
	input wire reset,
	input wire ce,
	// avalon-mm slave
	input wire [11:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	input wire [3:0] avs_byteenable,
	output wire [31:0] avs_readdata,
	output wire [1:0] avs_response,
	output wire avs_waitrequest,
	// power state
	input wire sleep_active,
	input wire deep_sleep_active,
	// peripheral accesses and clock enables
	input wire [10:0] unit_access,
	output wire unit_fault,
	output wire [10:0] unit_clk_en,
	// interrupt
	output wire irq
);

	// ------------------------------------------------------------------
	// bus state machine
	// ------------------------------------------------------------------
	localparam [1:0] ST_IDLE = 2'b01;
	localparam [1:0] ST_ACK = 2'b10;

	reg [1:0] st_r;
	reg [1:0] st_nxt;

	// ------------------------------------------------------------------
	// registers
	// ------------------------------------------------------------------
	reg [31:0] run_gate_ctrl_r;
	reg [31:0] sleep_gate_ctrl_r;
	reg [31:0] deep_sleep_gate_ctrl_r;
	reg [31:0] run_clock_config_r;
	reg [31:0] irq_status_r;
	reg [31:0] irq_mask_r;
	reg [31:0] readdata_r;
	reg [31:0] readdata_nxt;
	reg [1:0] response_r;
	reg [1:0] response_nxt;
	reg waitrequest_r;
	reg unit_fault_r;
	reg irq_r;

	wire [10:0] eff_en;
	wire [31:0] eff_word;
	wire auto_gate_select;
	wire use_sleep;
	wire use_deep;
	wire req;
	wire accept;
	wire wr_accept;
	wire rd_accept;
	wire addr_mapped;
	wire fault_evt;
	wire unmap_evt;
	wire [31:0] irq_set;
	wire [31:0] irq_clr;

	// ------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------
	// bit position of unit i within the gating layout
	function [4:0] unit_pos;
		input integer i;
		begin
			case (i)
				0: unit_pos = `SCG_BIT_UART_PORT_ZERO_GATE; // (R11)
				1: unit_pos = `SCG_BIT_UART_PORT_ONE_GATE; // (R11)
				2: unit_pos = `SCG_BIT_UART_PORT_TWO_GATE; // (R11)
				3: unit_pos = `SCG_BIT_SYNC_SERIAL_ZERO_GATE; // (R10)
				4: unit_pos = `SCG_BIT_SYNC_SERIAL_ONE_GATE; // (R10)
				5: unit_pos = `SCG_BIT_I2C_PORT_ZERO_GATE; // (R09)
				6: unit_pos = `SCG_BIT_GPT0; // (R08)
				7: unit_pos = `SCG_BIT_GPT1; // (R08)
				8: unit_pos = `SCG_BIT_GPT2; // (R08)
				9: unit_pos = `SCG_BIT_GPT3; // (R08)
				default: unit_pos = `SCG_BIT_COMPARATOR_ZERO_GATE; // (R07)
			endcase
		end
	endfunction

	// word-aligned address match; low two address bits are ignored
	function addr_is;
		input [11:0] addr;
		input [11:0] off;
		begin
			addr_is = (addr[11:2] == off[11:2]);
		end
	endfunction

	// byte-lane write merge; bits outside impl keep reading zero
	function [31:0] lane_merge;
		input [31:0] old;
		input [31:0] wdata;
		input [3:0] be;
		input [31:0] impl;
		reg [31:0] lanes;
		begin
			lanes = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
			lane_merge = ((old & ~lanes) | (wdata & lanes)) & impl;
		end
	endfunction

	// ------------------------------------------------------------------
	// power state selection
	// ------------------------------------------------------------------
	assign auto_gate_select = run_clock_config_r[`SCG_CFG_AUTO_BIT];
	// without automatic gating the run register governs every state
	assign use_deep = auto_gate_select & deep_sleep_active; // (R06)
	assign use_sleep = auto_gate_select & sleep_active; // (R06)

	genvar g;
	generate
		for (g = 0; g < `SCG_NUM_UNITS; g = g + 1) begin : gen_unit
			localparam [4:0] POS = unit_pos(g);
			scg_gate_cell u_cell (
				.clk(clk),
				.reset(reset),
				.ce(ce),
				.run_en(run_gate_ctrl_r[POS]),
				.sleep_en(sleep_gate_ctrl_r[POS]),
				.deep_en(deep_sleep_gate_ctrl_r[POS]),
				.use_sleep(use_sleep),
				.use_deep(use_deep),
				.gate_en(eff_en[g])
			); // (R14)
			assign eff_word[POS] = eff_en[g];
		end
	endgenerate

	// reserved positions of the effective-enable view read zero
	assign eff_word[31:25] = 7'h00;
	assign eff_word[23:20] = 4'h0;
	assign eff_word[15:13] = 3'h0;
	assign eff_word[11:6] = 6'h00;
	assign eff_word[3] = 1'b0;

	// ------------------------------------------------------------------
	// bus decode
	// ------------------------------------------------------------------
	assign req = avs_read | avs_write;
	// the request completes at the edge where waitrequest is seen low
	assign accept = req & (st_r == ST_ACK);
	assign wr_accept = accept & avs_write;
	assign rd_accept = accept & avs_read;

	assign addr_mapped = addr_is(avs_address, `SCG_OFF_RUN_GATE) |
		addr_is(avs_address, `SCG_OFF_SLEEP_GATE) |
		addr_is(avs_address, `SCG_OFF_DEEP_GATE) |
		addr_is(avs_address, `SCG_OFF_RUN_CFG) |
		addr_is(avs_address, `SCG_OFF_IRQ_STATUS) |
		addr_is(avs_address, `SCG_OFF_IRQ_MASK) |
		addr_is(avs_address, `SCG_OFF_EFF_GATE);

	always @* begin
		st_nxt = st_r;
		case (st_r)
			ST_IDLE: begin
				if (req) begin
					st_nxt = ST_ACK;
				end
			end
			ST_ACK: begin
				st_nxt = ST_IDLE;
			end
			default: begin
				st_nxt = ST_IDLE;
			end
		endcase
	end

	// read data and response are prepared one cycle ahead, so they stand
	// from the cycle waitrequest drops until the accepting edge
	always @* begin
		readdata_nxt = 32'h00000000;
		response_nxt = `SCG_RESP_OKAY;
		if (req && st_r == ST_IDLE) begin
			if (!addr_mapped) begin
				response_nxt = `SCG_RESP_SLVERR;
			end else if (avs_read) begin
				if (addr_is(avs_address, `SCG_OFF_RUN_GATE)) begin
					readdata_nxt = run_gate_ctrl_r; // (R13)
				end
				if (addr_is(avs_address, `SCG_OFF_SLEEP_GATE)) begin
					readdata_nxt = sleep_gate_ctrl_r; // (R01)
				end
				if (addr_is(avs_address, `SCG_OFF_DEEP_GATE)) begin
					readdata_nxt = deep_sleep_gate_ctrl_r;
				end
				if (addr_is(avs_address, `SCG_OFF_RUN_CFG)) begin
					readdata_nxt = run_clock_config_r;
				end
				if (addr_is(avs_address, `SCG_OFF_IRQ_STATUS)) begin
					readdata_nxt = irq_status_r;
				end
				if (addr_is(avs_address, `SCG_OFF_IRQ_MASK)) begin
					readdata_nxt = irq_mask_r;
				end
				if (addr_is(avs_address, `SCG_OFF_EFF_GATE)) begin
					readdata_nxt = eff_word;
				end
			end
		end
	end

	always @(posedge clk) begin
		if (reset) begin
			st_r <= ST_IDLE;
			waitrequest_r <= 1'b1;
			readdata_r <= 32'h00000000;
			response_r <= `SCG_RESP_OKAY;
		end else if (ce) begin
			st_r <= st_nxt;
			waitrequest_r <= (st_nxt != ST_ACK);
			if (st_r == ST_IDLE) begin
				readdata_r <= readdata_nxt;
				response_r <= response_nxt;
			end
		end
	end

	// ------------------------------------------------------------------
	// gating and configuration registers
	// ------------------------------------------------------------------
	always @(posedge clk) begin
		if (reset) begin
			run_gate_ctrl_r <= `SCG_GATE_RESET; // (R04)
			sleep_gate_ctrl_r <= `SCG_GATE_RESET; // (R01)
			deep_sleep_gate_ctrl_r <= `SCG_GATE_RESET; // (R04)
			run_clock_config_r <= `SCG_CFG_RESET;
			irq_mask_r <= `SCG_IRQ_RESET;
		end else if (ce && wr_accept) begin
			if (addr_is(avs_address, `SCG_OFF_RUN_GATE)) begin
				run_gate_ctrl_r <= lane_merge(run_gate_ctrl_r,
					avs_writedata, avs_byteenable,
					`SCG_GATE_IMPL); // (R13)
			end
			if (addr_is(avs_address, `SCG_OFF_SLEEP_GATE)) begin
				sleep_gate_ctrl_r <= lane_merge(sleep_gate_ctrl_r,
					avs_writedata, avs_byteenable,
					`SCG_GATE_IMPL); // (R12)
			end
			if (addr_is(avs_address, `SCG_OFF_DEEP_GATE)) begin
				deep_sleep_gate_ctrl_r <= lane_merge(
					deep_sleep_gate_ctrl_r, avs_writedata,
					avs_byteenable, `SCG_GATE_IMPL);
			end
			if (addr_is(avs_address, `SCG_OFF_RUN_CFG)) begin
				run_clock_config_r <= lane_merge(run_clock_config_r,
					avs_writedata, avs_byteenable,
					32'h00000001 << `SCG_CFG_AUTO_BIT);
			end
			if (addr_is(avs_address, `SCG_OFF_IRQ_MASK)) begin
				irq_mask_r <= lane_merge(irq_mask_r, avs_writedata,
					avs_byteenable, `SCG_IRQ_IMPL);
			end
		end
	end

	// ------------------------------------------------------------------
	// bus fault on gated units
	// ------------------------------------------------------------------
	// judged against the enable the unit actually sees this cycle
	assign fault_evt = |(unit_access & ~eff_en); // (R03)
	assign unmap_evt = accept & ~addr_mapped;

	always @(posedge clk) begin
		if (reset) begin
			unit_fault_r <= 1'b0;
		end else if (ce) begin
			unit_fault_r <= fault_evt; // (R03)
		end
	end

	// ------------------------------------------------------------------
	// interrupt status and mask
	// ------------------------------------------------------------------
	assign irq_set = ({31'h00000000, fault_evt} << `SCG_IRQ_FAULT_BIT) |
		({31'h00000000, unmap_evt} << `SCG_IRQ_UNMAP_BIT);
	// a read clears only the bits it returned, so an event that lands
	// while the read waits for its accepting edge stays pending
	assign irq_clr = (rd_accept &&
		addr_is(avs_address, `SCG_OFF_IRQ_STATUS)) ?
		(readdata_r & `SCG_IRQ_IMPL) : 32'h00000000;

	// an event in the clearing cycle survives: set beats clear
	always @(posedge clk) begin
		if (reset) begin
			irq_status_r <= `SCG_IRQ_RESET;
			irq_r <= 1'b0;
		end else if (ce) begin
			irq_status_r <= ((irq_status_r & ~irq_clr) | irq_set) &
				`SCG_IRQ_IMPL;
			irq_r <= |(((irq_status_r & ~irq_clr) | irq_set) &
				irq_mask_r);
		end
	end

	// ------------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------------
	assign avs_readdata = readdata_r;
	assign avs_response = response_r;
	assign avs_waitrequest = waitrequest_r;
	assign unit_fault = unit_fault_r;
	assign unit_clk_en = eff_en; // (R02)
	assign irq = irq_r;

endmodule // scg_sleep_gate

`default_nettype wire

/* dv/scg_sleep_gate_checker.sv */
// scg_sleep_gate_checker.sv: port assertions for scg_sleep_gate.
// assumes: ce low only while the bus and unit strobes are idle; bound to
// every instance.
`timescale 1ns/1ps
`default_nettype none
`include "scg_defs.vh"
module scg_sleep_gate_checker (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	input wire logic ce,
	// avalon-mm slave
	input wire logic [11:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic [1:0] avs_response,
	input wire logic avs_waitrequest,
	// power state and units
	input wire logic sleep_active,
	input wire logic deep_sleep_active,
	input wire logic [10:0] unit_access,
	input wire logic unit_fault,
	input wire logic [10:0] unit_clk_en,
	input wire logic irq
);
	// ------------------------------------------------------------------
	// shadow of writable registers
	// ------------------------------------------------------------------
	logic [31:0] run_r, sl_r, dp_r;
	logic auto_r, msk_r;
	wire [11:0] wa = {avs_address[11:2], 2'h0};
	wire done = (avs_read || avs_write) && !avs_waitrequest && ce;
	wire [31:0] bm = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
		{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
	wire [31:0] wd = avs_writedata & bm & `SCG_GATE_IMPL;
	wire [31:0] sel = !auto_r ? run_r : deep_sleep_active ? dp_r :
		sleep_active ? sl_r : run_r;
	wire [10:0] exp_en = {sel[24], sel[19:16], sel[12], sel[5:4], sel[2:0]};
	wire mapped = wa == `SCG_OFF_RUN_GATE || wa == `SCG_OFF_SLEEP_GATE ||
		wa == `SCG_OFF_DEEP_GATE || wa == `SCG_OFF_RUN_CFG ||
		wa == `SCG_OFF_IRQ_STATUS || wa == `SCG_OFF_IRQ_MASK ||
		wa == `SCG_OFF_EFF_GATE;
	always @(posedge clk) begin
		if (reset) begin
			run_r <= 32'h0;
			sl_r <= 32'h0;
			dp_r <= 32'h0;
			auto_r <= 1'b0;
			msk_r <= 1'b0;
		end else if (done && avs_write) begin
			if (wa == `SCG_OFF_RUN_GATE) run_r <= (run_r & ~bm) | wd;
			if (wa == `SCG_OFF_SLEEP_GATE) sl_r <= (sl_r & ~bm) | wd;
			if (wa == `SCG_OFF_DEEP_GATE) dp_r <= (dp_r & ~bm) | wd;
			if (wa == `SCG_OFF_RUN_CFG && avs_byteenable[0])
				auto_r <= avs_writedata[0];
			if (wa == `SCG_OFF_IRQ_MASK && avs_byteenable[0])
				msk_r <= avs_writedata[0];
		end
	end
	// ------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	a_reset_all_off: assert property (disable iff (1'b0) reset && ce |=>
		unit_clk_en == 11'h0 && !irq && !unit_fault && avs_waitrequest)
		else $error("outputs not cleared by reset");
	a_fault_gated_unit: assert property (
		(unit_access & ~unit_clk_en) != 0 |=> unit_fault)
		else $error("no fault for access to gated unit");
	a_no_fault_clocked: assert property (
		(unit_access & ~unit_clk_en) == 0 |=> !unit_fault)
		else $error("fault without gated access");
	a_one_wait_cycle: assert property ($rose(avs_read || avs_write) |->
		avs_waitrequest ##1 !avs_waitrequest ##1 avs_waitrequest)
		else $error("bus answer not after one wait cycle");
	a_sleep_readback: assert property (done && avs_read &&
		wa == `SCG_OFF_SLEEP_GATE |->
		avs_readdata == sl_r && avs_response == `SCG_RESP_OKAY)
		else $error("sleep gating readback wrong");
	a_reserved_zero: assert property (done && avs_read &&
		(wa == `SCG_OFF_RUN_GATE || wa == `SCG_OFF_SLEEP_GATE ||
		wa == `SCG_OFF_DEEP_GATE) |->
		(avs_readdata & ~`SCG_GATE_IMPL) == 32'h0)
		else $error("reserved bits not zero");
	a_unmapped_error: assert property (done && !mapped |->
		avs_response == `SCG_RESP_SLVERR &&
		(avs_write || avs_readdata == 32'h0))
		else $error("unmapped access not refused");
	a_effective_select: assert property (!$past(reset) && $past(ce) |->
		unit_clk_en == $past(exp_en))
		else $error("effective enable does not follow power state");
	a_fault_raises_irq: assert property (unit_fault && msk_r |=> irq)
		else $error("masked-in fault did not raise interrupt");
	c_sleep_write: cover property (done && avs_write && wa == `SCG_OFF_SLEEP_GATE);
	c_fault: cover property (unit_fault);
	c_irq: cover property (irq);
	c_unmapped: cover property (done && !mapped);
endmodule // scg_sleep_gate_checker

bind scg_sleep_gate scg_sleep_gate_checker chk (.clk(clk), .reset(reset),
	.ce(ce),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
	.avs_readdata(avs_readdata), .avs_response(avs_response),
	.avs_waitrequest(avs_waitrequest), .sleep_active(sleep_active),
	.deep_sleep_active(deep_sleep_active), .unit_access(unit_access),
	.unit_fault(unit_fault), .unit_clk_en(unit_clk_en), .irq(irq));
`default_nettype wire

/* dv/tb.sv */
// tb.sv: self-checking bench for scg_sleep_gate over avalon-mm.
// assumes: scg_defs.vh on the include path; ce dropped only while idle.
`timescale 1ns/1ps
`default_nettype none
`include "scg_defs.vh"
module tb;
	// ------------------------------------------------------------------
	// signals
	// ------------------------------------------------------------------
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic ce = 1'b1;
	logic [11:0] avs_address = 12'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0] avs_byteenable = 4'h0;
	logic sleep_active = 1'b0;
	logic deep_sleep_active = 1'b0;
	logic [10:0] unit_access = 11'h0;
	wire [31:0] avs_readdata;
	wire [1:0] avs_response;
	wire avs_waitrequest, unit_fault, irq;
	wire [10:0] unit_clk_en;
	logic [31:0] rdata;
	logic [1:0] resp;
	int num_errors = 0;
	int checked = 0;
	int pos [11] = '{0, 1, 2, 4, 5, 12, 16, 17, 18, 19, 24};
	localparam logic [11:0] SLP = `SCG_OFF_SLEEP_GATE;
	localparam logic [11:0] CFG = `SCG_OFF_RUN_CFG;
	localparam logic [11:0] STAT = `SCG_OFF_IRQ_STATUS;
	always #2 clk = ~clk;
	scg_sleep_gate dut (.clk(clk), .reset(reset), .ce(ce),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_response(avs_response),
		.avs_waitrequest(avs_waitrequest), .sleep_active(sleep_active),
		.deep_sleep_active(deep_sleep_active), .unit_access(unit_access),
		.unit_fault(unit_fault), .unit_clk_en(unit_clk_en), .irq(irq));
	// ------------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------------
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: saw %h, expected %h", $time, got, exp);
		end
	endtask
	// request held until waitrequest is seen low at a rising edge
	task automatic bus(input logic rd, input logic [11:0] a,
		input logic [31:0] d, input logic [3:0] be);
		@(posedge clk);
		avs_read <= rd;
		avs_write <= !rd;
		avs_address <= a;
		avs_writedata <= d;
		avs_byteenable <= be;
		// no local limit: only the watchdog ends a wait that never ends
		do begin
			@(posedge clk);
		end while (avs_waitrequest !== 1'b0);
		rdata = avs_readdata;
		resp = avs_response;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		bus(1'b0, a, d, 4'hf);
	endtask
	task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
		bus(1'b1, a, 32'h0, 4'hf);
		check(rdata, exp);
	endtask
	task automatic en_chk(input logic [10:0] exp);
		repeat (2) @(posedge clk);
		check({21'h0, unit_clk_en}, {21'h0, exp});
	endtask
	// one-cycle access strobe, fault looked at in the cycle after it
	task automatic strobe(input logic [10:0] m, input logic f);
		@(posedge clk);
		unit_access <= m;
		@(posedge clk);
		unit_access <= 11'h0;
		@(posedge clk);
		check({31'h0, unit_fault}, {31'h0, f});
	endtask
	task results;
		$display("comparisons %0d, mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// ------------------------------------------------------------------
	// tests
	// ------------------------------------------------------------------
	initial begin
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		rd_chk(SLP, `SCG_GATE_RESET);
		check({21'h0, unit_clk_en}, 32'h0);
		wr(SLP, 32'hffffffff);
		rd_chk(SLP, `SCG_GATE_IMPL);
		bus(1'b0, SLP, 32'h0, 4'h1);
		rd_chk(SLP, 32'h010f1000);
		wr(`SCG_OFF_RUN_GATE, 32'h00000005);
		rd_chk(`SCG_OFF_RUN_GATE, 32'h00000005);
		wr(`SCG_OFF_DEEP_GATE, 32'h00080000);
		wr(CFG, 32'h1);
		sleep_active <= 1'b1;
		for (int i = 0; i < 11; i++) begin
			wr(SLP, 32'h1 << pos[i]);
			en_chk(11'h1 << i);
		end
		deep_sleep_active <= 1'b1;
		en_chk(11'h200);
		deep_sleep_active <= 1'b0;
		wr(CFG, 32'h0);
		en_chk(11'h005);
		wr(CFG, 32'h1);
		sleep_active <= 1'b0;
		en_chk(11'h005);
		sleep_active <= 1'b1;
		en_chk(11'h400);
		wr(SLP, 32'h1);
		wr(`SCG_OFF_IRQ_MASK, 32'h1);
		en_chk(11'h001);
		rd_chk(`SCG_OFF_EFF_GATE, 32'h1);
		// clock enable low freezes the selection despite a state change
		ce <= 1'b0;
		sleep_active <= 1'b0;
		en_chk(11'h001);
		ce <= 1'b1;
		en_chk(11'h005);
		sleep_active <= 1'b1;
		en_chk(11'h001);
		strobe(11'h001, 1'b0);
		strobe(11'h002, 1'b1);
		@(posedge clk);
		check({31'h0, irq}, 32'h1);
		rd_chk(STAT, 32'h1);
		repeat (2) @(posedge clk);
		check({31'h0, irq}, 32'h0);
		bus(1'b1, 12'h200, 32'h0, 4'hf);
		check({30'h0, resp}, {30'h0, `SCG_RESP_SLVERR});
		check(rdata, 32'h0);
		bus(1'b0, 12'h204, 32'hffffffff, 4'hf);
		check({30'h0, resp}, {30'h0, `SCG_RESP_SLVERR});
		rd_chk(STAT, 32'h2);
		check({31'h0, irq}, 32'h0);
		@(posedge clk);
		reset <= 1'b1;
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		rd_chk(SLP, `SCG_GATE_RESET);
		en_chk(11'h000);
		strobe(11'h400, 1'b1);
		results;
	end
	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		$display("Error at %0t: watchdog expired", $time);
		results;
	end
endmodule // tb
`default_nettype wire
